// File: ids_defines.vh
// Constants for the ISA DMA status and window base block
`ifndef IDS_DEFINES_VH
`define IDS_DEFINES_VH
// Register indices (printed offsets are not word aligned)
`define IDS_IDX_IO_BASE 16'h7f71
`define IDS_IDX_MEM_BASE 16'h7f72
`define IDS_IDX_STAT 16'h7f73
`define IDS_IDX_MASK 16'h7f74
// Own registers
`define IDS_IDX_ISR0 16'h7f75
`define IDS_IDX_CTRL 16'h7f76
`define IDS_ADDR_W 18
`define IDS_IO_BASE_RST 8'h00
`define IDS_MEM_BASE_RST 8'h00
`define IDS_MASK_RST 8'hff
`define IDS_CTRL_RST 8'h00
// Control register fields
`define IDS_CTRL_GRANT 0
`define IDS_CTRL_INH_LO 4
`define IDS_CTRL_INH_HI 7
// Interrupt status 0 field
`define IDS_ISR0_DMA 0
// Wait state counts per clock ratio
`define IDS_WS_W 3
`define IDS_WS_NONE 3'h0
`define IDS_WS_SLOW 3'h3
// Speed codes: 0=24/2, 1=24/4, 2=12/2, 3=other
`define IDS_SPD_24_2 2'h0
`define IDS_SPD_24_4 2'h1
`define IDS_SPD_12_2 2'h2
`define IDS_RESP_OKAY 2'h0
`define IDS_RESP_SLVERR 2'h2
// Grant release time
`define IDS_RELEASE_NS 1500
`define IDS_CLK_NS 100
`define IDS_RELEASE_CYC ((`IDS_RELEASE_NS + `IDS_CLK_NS - 1) / `IDS_CLK_NS)
`endif

// File: ids_dma_model.sv
// DMA engine channel status model
`timescale 1ns/1ps
module ids_dma_model (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bench stimulus
  input wire [3:0] req_lvl,
  input wire [3:0] done_set,
  // Device side
  input wire clr,
  output reg [7:0] status_q
);
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= 8'h00;
    end else begin
      status_q[7:4] <= req_lvl;
      // Set wins over a clear in the same cycle
      status_q[3:0] <= (status_q[3:0] & ~{4{clr}}) | done_set;
    end
  end
endmodule // ids_dma_model

// File: ids_edge_latch.v
// Rising edge detector with mask and sticky flag
`timescale 1ns/1ps
`include "ids_defines.vh"
module ids_edge_latch (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Status and mask
  input wire [7:0] status,
  input wire [7:0] mask,
  // Flag control
  input wire clear,
  output reg flag_q
);
  reg [7:0] prev_q;
  wire [7:0] rise;
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      assign rise[i] = status[i] & ~prev_q[i] & ~mask[i];
    end
  endgenerate
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 8'h00;
      flag_q <= 1'b0;
    end else begin
      prev_q <= status;
      // Set wins over a clear in the same cycle
      if (|rise)
        flag_q <= 1'b1;
      else if (clear)
        flag_q <= 1'b0;
    end
  end
endmodule // ids_edge_latch

// File: ids_top.v
// AXI4-Lite register block: DMA status mirror, mask, interrupt and ISA window bases
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ids_defines.vh"
module ids_top (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [`IDS_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [`IDS_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // DMA engine channel status and clear
  input wire [7:0] dma_channel_status,
  output wire dma_count_done_clear,
  // Memory-to-memory cycle in progress
  input wire dma_mem_to_mem,
  // Per-channel terminal count from engine and to ISA end-of-process
  input wire [3:0] dma_count_done_raw,
  output wire [3:0] isa_count_done_out,
  // Microcontroller window access
  input wire win_io_req,
  input wire win_mem_req,
  input wire win_write,
  input wire [11:0] win_offset,
  input wire win_offset_reads_status,
  input wire [1:0] clock_speed_sel,
  output wire win_busy,
  // ISA address and strobes
  output reg [19:0] isa_addr_q,
  output reg isa_io_read_q,
  output reg isa_io_write_q,
  output reg isa_mem_read_q,
  output reg isa_mem_write_q,
  // Bus grant and interrupt flag
  output wire bus_grant_bit,
  output wire dma_release_pending,
  output wire dma_interrupt_flag
);
  reg [7:0] io_window_base_q;
  reg [7:0] memory_window_base_q;
  reg [7:0] status_mask_q;
  reg [7:0] ctrl_q;
  reg [`IDS_ADDR_W-1:0] awaddr_q;
  reg aw_held_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_held_q;
  reg [4:0] release_cnt_q;
  wire [31:0] release_full;
  reg [31:0] rdata_d;
  reg rerr_d;
  reg isr_clear;
  wire [15:0] widx;
  wire [15:0] ridx;
  wire wr_fire;
  wire rd_fire;
  wire ws_busy;
  wire win_start;
  wire [3:0] inhibit;

  // Write channel: address and data taken independently
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign widx = awaddr_q[17:2];
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign ridx = s_axi_araddr[17:2];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= {`IDS_ADDR_W{1'b0}};
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IDS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (widx == `IDS_IDX_IO_BASE || widx == `IDS_IDX_MEM_BASE ||
                        widx == `IDS_IDX_MASK || widx == `IDS_IDX_ISR0 ||
                        widx == `IDS_IDX_CTRL || widx == `IDS_IDX_STAT) ?
                       `IDS_RESP_OKAY : `IDS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes, low byte lane only
  always @(posedge aclk) begin
    if (!aresetn) begin
      io_window_base_q <= `IDS_IO_BASE_RST;
      memory_window_base_q <= `IDS_MEM_BASE_RST;
      status_mask_q <= `IDS_MASK_RST;
      ctrl_q <= `IDS_CTRL_RST;
    end else if (wr_fire && wstrb_q[0]) begin
      case (widx)
        `IDS_IDX_IO_BASE: io_window_base_q <= wdata_q[7:0];
        `IDS_IDX_MEM_BASE: memory_window_base_q <= wdata_q[7:0];
        `IDS_IDX_MASK: status_mask_q <= wdata_q[7:0];
        `IDS_IDX_CTRL: ctrl_q <= wdata_q[7:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Write one to clear the interrupt flag
  always @* begin
    isr_clear = wr_fire && wstrb_q[0] && widx == `IDS_IDX_ISR0 && wdata_q[`IDS_ISR0_DMA];
  end

  ids_edge_latch u_latch (
    .aclk(aclk),
    .aresetn(aresetn),
    .status(dma_channel_status),
    .mask(status_mask_q),
    .clear(isr_clear),
    .flag_q(dma_interrupt_flag)
  );

  // Read mux; mirror read is combinational view with no side effect
  always @* begin
    rdata_d = 32'h0000_0000;
    rerr_d = 1'b0;
    case (ridx)
      `IDS_IDX_IO_BASE: rdata_d[7:0] = io_window_base_q;
      `IDS_IDX_MEM_BASE: rdata_d[7:0] = memory_window_base_q;
      `IDS_IDX_STAT: rdata_d[7:0] = dma_channel_status;
      `IDS_IDX_MASK: rdata_d[7:0] = status_mask_q;
      `IDS_IDX_ISR0: rdata_d[`IDS_ISR0_DMA] = dma_interrupt_flag;
      `IDS_IDX_CTRL: rdata_d[7:0] = ctrl_q;
      default: rerr_d = 1'b1;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IDS_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rerr_d ? `IDS_RESP_SLVERR : `IDS_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Bus grant and release window
  assign bus_grant_bit = ctrl_q[`IDS_CTRL_GRANT];
  // Count constant is integer sized; only the low bits fit the counter
  assign release_full = `IDS_RELEASE_CYC;
  always @(posedge aclk) begin
    if (!aresetn)
      release_cnt_q <= 5'h00;
    else if (wr_fire && wstrb_q[0] && widx == `IDS_IDX_CTRL && bus_grant_bit &&
             !wdata_q[`IDS_CTRL_GRANT])
      release_cnt_q <= release_full[4:0];
    else if (release_cnt_q != 5'h00)
      release_cnt_q <= release_cnt_q - 5'h01;
  end
  assign dma_release_pending = (release_cnt_q != 5'h00);

  // Count-done inhibit bypassed for memory-to-memory
  assign inhibit = ctrl_q[`IDS_CTRL_INH_HI:`IDS_CTRL_INH_LO];
  assign isa_count_done_out = dma_count_done_raw & ~(inhibit & {4{~dma_mem_to_mem}});

  // Window access: no new cycle while granted or waiting
  assign win_start = (win_io_req || win_mem_req) && !ws_busy && !bus_grant_bit;
  assign win_busy = ws_busy || bus_grant_bit;

  ids_wait_gen u_wait (
    .aclk(aclk),
    .aresetn(aresetn),
    .speed_sel(clock_speed_sel),
    .start(win_start),
    .busy(ws_busy)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      isa_addr_q <= 20'h00000;
      isa_io_read_q <= 1'b0;
      isa_io_write_q <= 1'b0;
      isa_mem_read_q <= 1'b0;
      isa_mem_write_q <= 1'b0;
    end else if (win_start) begin
      if (win_io_req) begin
        isa_addr_q <= {4'h0, io_window_base_q, win_offset[7:0]};
        isa_io_read_q <= !win_write;
        isa_io_write_q <= win_write;
      end else begin
        isa_addr_q <= {memory_window_base_q, win_offset};
        isa_mem_read_q <= !win_write;
        isa_mem_write_q <= win_write;
      end
    end else if (!ws_busy) begin
      isa_io_read_q <= 1'b0;
      isa_io_write_q <= 1'b0;
      isa_mem_read_q <= 1'b0;
      isa_mem_write_q <= 1'b0;
    end
  end

  // Engine clears its count bits on an I/O window read of its status
  assign dma_count_done_clear = win_start && win_io_req && !win_write && win_offset_reads_status;
endmodule // ids_top

// File: ids_top_asserts.sv
// Checker for the ids_top ports
`timescale 1ns/1ps
module ids_top_asserts (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_bvalid,
  // Window
  input wire [11:0] win_offset,
  input wire win_write,
  input wire [1:0] clock_speed_sel,
  input wire win_busy,
  input wire [19:0] isa_addr_q,
  input wire isa_io_read_q,
  input wire isa_io_write_q,
  input wire isa_mem_read_q,
  input wire isa_mem_write_q,
  // Control, count done, flag
  input wire bus_grant_bit,
  input wire dma_interrupt_flag,
  input wire dma_mem_to_mem,
  input wire [3:0] dma_count_done_raw,
  input wire [3:0] isa_count_done_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire strb = isa_io_read_q | isa_io_write_q | isa_mem_read_q | isa_mem_write_q;
  a_io_addr: assert property ($rose(isa_io_read_q) |->
    isa_addr_q[7:0] == $past(win_offset[7:0]) && !$past(win_write)) else $error("io address wrong");
  a_mem_addr: assert property ($rose(isa_mem_write_q) |->
    isa_addr_q[11:0] == $past(win_offset) && $past(win_write)) else $error("mem address wrong");
  a_strobe_len: assert property ($rose(strb) && $past(clock_speed_sel) != 2'h3 |->
    strb [*4] ##1 !strb) else $error("strobe length wrong");
  a_tc_pass: assert property ((isa_count_done_out & ~dma_count_done_raw) == 4'h0)
    else $error("count done without cause");
  a_m2m_tc: assert property (dma_mem_to_mem |-> isa_count_done_out == dma_count_done_raw)
    else $error("count done inhibited in m2m");
  a_flag_hold: assert property ($fell(dma_interrupt_flag) |-> ##[0:2] s_axi_bvalid)
    else $error("flag dropped without write");
  a_grant_busy: assert property (bus_grant_bit |-> win_busy)
    else $error("window free while granted");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  cover property ($rose(dma_interrupt_flag));
  cover property ($rose(isa_mem_write_q));
  cover property (dma_mem_to_mem && |dma_count_done_raw);
endmodule // ids_top_asserts
bind ids_top ids_top_asserts i_chk (.*);

// File: ids_wait_gen.v
// Wait state counter for ISA side accesses
`timescale 1ns/1ps
`include "ids_defines.vh"
module ids_wait_gen (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Access
  input wire [1:0] speed_sel,
  input wire start,
  output wire busy
);
  reg [`IDS_WS_W-1:0] cnt_q;
  wire [`IDS_WS_W-1:0] load;
  // Slow DMA clock pairs need extra cycles
  assign load = (speed_sel == `IDS_SPD_24_2 || speed_sel == `IDS_SPD_24_4 ||
                 speed_sel == `IDS_SPD_12_2) ? `IDS_WS_SLOW : `IDS_WS_NONE;
  assign busy = (cnt_q != `IDS_WS_NONE);
  always @(posedge aclk) begin
    if (!aresetn)
      cnt_q <= `IDS_WS_NONE;
    else if (start)
      cnt_q <= load;
    else if (busy)
      cnt_q <= cnt_q - 3'h1;
  end
endmodule // ids_wait_gen

// File: tb_ids_top.sv
// Testbench for ids_top
`timescale 1ns/1ps
module tb_ids_top;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [17:0] aw = 18'h0, ar = 18'h0;
  logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
  logic [31:0] wd = 32'h0;
  wire awr, wr_rdy, bv, arr, rv, clr, busy, grant, flag, ior, iow, mr, mw, rel;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] stat;
  wire [3:0] tco;
  wire [19:0] addr;
  logic m2m = 1'h0, ioq = 1'h0, mq = 1'h0, we = 1'h0, rs = 1'h0;
  logic [3:0] raw = 4'h0, req = 4'h0, dset = 4'h0;
  logic [11:0] off = 12'h0;
  logic [1:0] spd = 2'h0;
  int miscompares = 0, tests_run = 0;
  always #50 aclk = ~aclk;
  ids_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .dma_channel_status(stat), .dma_count_done_clear(clr), .dma_mem_to_mem(m2m), .dma_count_done_raw(raw),
    .isa_count_done_out(tco), .win_io_req(ioq), .win_mem_req(mq), .win_write(we), .win_offset(off),
    .win_offset_reads_status(rs), .clock_speed_sel(spd), .win_busy(busy), .isa_addr_q(addr),
    .isa_io_read_q(ior), .isa_io_write_q(iow), .isa_mem_read_q(mr), .isa_mem_write_q(mw),
    .bus_grant_bit(grant), .dma_release_pending(rel), .dma_interrupt_flag(flag));
  ids_dma_model i_dma (.aclk(aclk), .aresetn(aresetn), .req_lvl(req), .done_set(dset), .clr(clr), .status_q(stat));
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic tmo(input bit ok);
    if (!ok) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a, w, b;
    b = 1'h0;
    aw <= {idx, 2'h0};
    wd <= {24'h0, d};
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    for (int n = 0; n < 20 && !b; n++) begin
      @(negedge aclk);
      a = awv & awr;
      w = wv & wr_rdy;
      b = bv;
      if (b) chk("bresp", er, bresp);
      @(posedge aclk);
      if (a) awv <= 1'h0;
      if (w) wv <= 1'h0;
    end
    br <= 1'h0;
    tmo(b);
  endtask
  task automatic rd(input string what, input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic a, b;
    b = 1'h0;
    ar <= {idx, 2'h0};
    arv <= 1'h1;
    rr <= 1'h1;
    for (int n = 0; n < 20 && !b; n++) begin
      @(negedge aclk);
      a = arv & arr;
      b = rv;
      if (b) chk(what, exp, rdata);
      if (b) chk("rresp", er, rresp);
      @(posedge aclk);
      if (a) arv <= 1'h0;
    end
    rr <= 1'h0;
    tmo(b);
  endtask
  // One window access; request dropped at the taking edge so it fires once
  task automatic win(input logic io, input logic w, input logic [11:0] o, input logic s, input logic [19:0] exp);
    logic t;
    t = 1'h0;
    ioq <= io;
    mq <= !io;
    we <= w;
    off <= o;
    rs <= s;
    for (int n = 0; n < 40 && !t; n++) begin
      @(negedge aclk);
      t = !busy;
      @(posedge aclk);
    end
    ioq <= 1'h0;
    mq <= 1'h0;
    tmo(t);
    @(negedge aclk);
    chk("isa_addr", exp, io ? {4'h0, addr[15:0]} : addr);
    chk("strobes", {io & !w, io & w, !io & !w, !io & w}, {ior, iow, mr, mw});
    repeat (6) @(posedge aclk);
  endtask
  task automatic pulse_done(input logic [3:0] v);
    dset <= v;
    @(posedge aclk);
    dset <= 4'h0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic t_reset;
    rd("mask", 16'h7f74, 32'hff, 2'h0);
    rd("io_base", 16'h7f71, 32'h0, 2'h0);
    rd("mem_base", 16'h7f72, 32'h0, 2'h0);
    rd("unmapped", 16'h0010, 32'h0, 2'h2);
    wr(16'h0010, 8'h55, 2'h2);
  endtask
  task automatic t_window;
    wr(16'h7f71, 8'ha5, 2'h0);
    rd("io_base", 16'h7f71, 32'ha5, 2'h0);
    win(1'h1, 1'h0, 12'h03c, 1'h0, 20'h0a53c);
    wr(16'h7f72, 8'h5a, 2'h0);
    spd <= 2'h3;
    win(1'h0, 1'h1, 12'habc, 1'h0, 20'h5aabc);
    spd <= 2'h1;
    win(1'h0, 1'h0, 12'h001, 1'h0, 20'h5a001);
  endtask
  task automatic t_status_irq;
    req <= 4'h9;
    pulse_done(4'h6);
    rd("status", 16'h7f73, 32'h96, 2'h0);
    rd("status", 16'h7f73, 32'h96, 2'h0);
    chk("flag", 1'h0, flag);
    req <= 4'h0;
    win(1'h1, 1'h0, 12'h008, 1'h1, 20'h0a508);
    rd("status", 16'h7f73, 32'h00, 2'h0);
    wr(16'h7f74, 8'hfe, 2'h0);
    pulse_done(4'h2);
    chk("flag", 1'h0, flag);
    pulse_done(4'h1);
    chk("flag", 1'h1, flag);
    win(1'h1, 1'h0, 12'h008, 1'h1, 20'h0a508);
    chk("flag", 1'h1, flag);
    wr(16'h7f75, 8'h01, 2'h0);
    @(negedge aclk);
    chk("flag", 1'h0, flag);
    @(posedge aclk);
    wr(16'h7f74, 8'hef, 2'h0);
    req <= 4'h1;
    repeat (4) @(posedge aclk);
    chk("flag", 1'h1, flag);
    req <= 4'h0;
    wr(16'h7f75, 8'h01, 2'h0);
  endtask
  task automatic t_inhibit_grant;
    wr(16'h7f76, 8'hf0, 2'h0);
    raw <= 4'hf;
    @(negedge aclk);
    chk("tc_out", 4'h0, tco);
    m2m <= 1'h1;
    @(negedge aclk);
    chk("tc_out", 4'hf, tco);
    @(posedge aclk);
    wr(16'h7f76, 8'h01, 2'h0);
    chk("grant", 2'h3, {grant, busy});
    mq <= 1'h1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("granted_strobes", 2'h0, {mr, mw});
    @(posedge aclk);
    mq <= 1'h0;
    wr(16'h7f76, 8'h00, 2'h0);
    @(negedge aclk);
    chk("release_pending", 1'h1, rel);
    repeat (14) @(posedge aclk);
    @(negedge aclk);
    chk("release_done", 1'h0, rel);
    @(posedge aclk);
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_window();
    t_status_irq();
    t_inhibit_grant();
    close_out();
  end
endmodule // tb_ids_top
